// file: lecap_cfg.svh
// lecap_cfg.svh: offsets, field positions, reset values and codes of the error capture bank
// assumes: included by bare name; every field position is given with bit 0 as the lsb
`ifndef LECAP_CFG_SVH
`define LECAP_CFG_SVH

// ----------------------------------------
// bus and register map
// ----------------------------------------
`define LECAP_AW 13
`define LECAP_OFF_ADDR 13'h1014
`define LECAP_OFF_DEVID 13'h1018
`define LECAP_OFF_CTRL 13'h101c
`define LECAP_OFF_STAT 13'h1030
`define LECAP_OFF_MASK 13'h1034
`define LECAP_RESET_WORD 32'h0000_0000

// ----------------------------------------
// field layouts (lsb numbering)
// ----------------------------------------
`define LECAP_ADDR_HI 23
`define LECAP_ADDR_LO 3
`define LECAP_WDPTR_BIT 1
`define LECAP_ADDR_WMASK 32'h00ff_fffa
`define LECAP_SRC_LO_HI 7
`define LECAP_SRC_LO_LO 0
`define LECAP_SRC_HI_HI 15
`define LECAP_SRC_HI_LO 8
`define LECAP_DEVID_WMASK 32'h0000_ffff
`define LECAP_FTYPE_HI 31
`define LECAP_FTYPE_LO 28
`define LECAP_TTYPE_HI 27
`define LECAP_TTYPE_LO 24
`define LECAP_CTRL_WMASK 32'hff00_0000
`define LECAP_CTRL_CLEAR 32'h0000_0000

// ----------------------------------------
// packet codes
// ----------------------------------------
`define LECAP_HOP_ZERO 8'h00
`define LECAP_FTYPE_MAINT 4'h8
`define LECAP_TT_SMALL 2'h0
`define LECAP_TT_LARGE 2'h1
`define LECAP_BYTE_ZERO 8'h00

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define LECAP_NIRQ 3
`define LECAP_IRQ_CAPTURE 0
`define LECAP_IRQ_MISSED 1
`define LECAP_IRQ_UNLOGGED 2

`endif

// file: lecap_pkg.sv
// lecap_pkg.sv: types shared by the error capture bank
// assumes: lecap_cfg.svh sits in the same folder
`include "lecap_cfg.svh"

package lecap_pkg;

   // ----------------------------------------
   // packet report from the logical layer
   // ----------------------------------------
   typedef enum logic [1:0] {
      lecap_req,
      lecap_resp,
      lecap_pwrite,
      lecap_other
   } lecap_kind_type;

   typedef struct packed {
      logic valid;
      lecap_kind_type kind;
      logic [7:0] hop;
      logic [1:0] tt;
      logic [3:0] ftype;
      logic [3:0] ttype;
      logic [15:0] srcid;
      logic [15:0] raw_b34;
      logic [20:0] addr;
      logic wdptr;
      logic err_ill_trans;
      logic err_ill_resp;
      logic err_unsup;
   } lecap_pkt_type;

   typedef struct packed {
      logic ill_trans_en;
      logic ill_resp_en;
      logic unsup_en;
   } lecap_en_type;

   typedef struct packed {
      logic [31:0] addr_word;
      logic [31:0] devid_word;
      logic [31:0] ctrl_word;
   } lecap_cap_type;

   typedef enum logic {
      lecap_open,
      lecap_locked
   } lecap_state_type;

endpackage : lecap_pkg

// file: lecap_pkt_decode.sv
// lecap_pkt_decode.sv: turns a packet report into capture words and log decisions
// assumes: report and enables come from logic on pclk; purely combinational
`timescale 1ns/1ps
`include "lecap_cfg.svh"
`default_nettype none

module lecap_pkt_decode (
   input wire lecap_pkg::lecap_pkt_type pkt,
   input wire lecap_pkg::lecap_en_type en,
   output logic err_seen,
   output logic log_hit,
   output lecap_pkg::lecap_cap_type cap
);

   logic maint_hop0;
   logic tt_defined;

   // ----------------------------------------
   // which errors may be logged
   // ----------------------------------------
   // only hop-zero maintenance traffic reaches this layer
   assign maint_hop0 = pkt.valid && (pkt.hop == `LECAP_HOP_ZERO)
      && (pkt.kind != lecap_pkg::lecap_other);
   // a failing but well formed request raises none of these flags
   assign err_seen = maint_hop0 && (pkt.err_ill_trans || pkt.err_ill_resp || pkt.err_unsup);
   assign log_hit = maint_hop0 && ((pkt.err_ill_trans && en.ill_trans_en)
      || (pkt.err_ill_resp && en.ill_resp_en)
      || (pkt.err_unsup && en.unsup_en));
   assign tt_defined = (pkt.tt == `LECAP_TT_SMALL) || (pkt.tt == `LECAP_TT_LARGE);

   // ----------------------------------------
   // capture words
   // ----------------------------------------
   always_comb begin
      cap = '0;
      // address position taken as is, whatever the kind or tt code
      cap.addr_word[`LECAP_ADDR_HI:`LECAP_ADDR_LO] = pkt.addr;
      cap.addr_word[`LECAP_WDPTR_BIT] = pkt.wdptr;
      if (!tt_defined) begin
         cap.devid_word[`LECAP_SRC_HI_HI:`LECAP_SRC_LO_LO] = pkt.raw_b34;
      end else begin
         cap.devid_word[`LECAP_SRC_LO_HI:`LECAP_SRC_LO_LO] = pkt.srcid[7:0];
         cap.devid_word[`LECAP_SRC_HI_HI:`LECAP_SRC_HI_LO] =
            (pkt.tt == `LECAP_TT_LARGE) ? pkt.srcid[15:8] : `LECAP_BYTE_ZERO;
      end
      // ftype is stored as seen; maintenance traffic gives eight
      cap.ctrl_word[`LECAP_FTYPE_HI:`LECAP_FTYPE_LO] = pkt.ftype;
      cap.ctrl_word[`LECAP_TTYPE_HI:`LECAP_TTYPE_LO] = pkt.ttype;
   end

endmodule : lecap_pkt_decode
`default_nettype wire

// file: lecap_irq.sv
// lecap_irq.sv: sticky event status, mask and the level interrupt
// assumes: one pclk domain; the bus slave hands in the value it returned as the clear mask
`timescale 1ns/1ps
`include "lecap_cfg.svh"
`default_nettype none

module lecap_irq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`LECAP_NIRQ-1:0] events,
   input wire logic rd_clr,
   input wire logic [`LECAP_NIRQ-1:0] clr_bits,
   input wire logic mask_wr,
   input wire logic [`LECAP_NIRQ-1:0] mask_wdata,
   output logic [`LECAP_NIRQ-1:0] status,
   output logic [`LECAP_NIRQ-1:0] mask,
   output logic irq
);

   logic [`LECAP_NIRQ-1:0] status_reg;
   logic [`LECAP_NIRQ-1:0] mask_reg;
   logic irq_reg;

   // ----------------------------------------
   // status: set wins over the read clear
   // ----------------------------------------
   // only bits that were returned are cleared, so a late event survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~({`LECAP_NIRQ{rd_clr}} & clr_bits)) | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= '0;
      end else if (mask_wr) begin
         mask_reg <= mask_wdata;
      end
   end

   // ----------------------------------------
   // interrupt output
   // ----------------------------------------
   // one cycle behind the status, but glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   assign status = status_reg;
   assign mask = mask_reg;
   assign irq = irq_reg;

endmodule : lecap_irq
`default_nettype wire

// file: lecap_top.sv
// lecap_top.sv: capture registers for errored hop-zero maintenance packets, apb slave
// assumes: packet reports and enables come from logic on pclk; apb master per the amba apb rules
`timescale 1ns/1ps
`include "lecap_cfg.svh"
`default_nettype none

module lecap_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`LECAP_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire lecap_pkg::lecap_pkt_type pkt,
   input wire lecap_pkg::lecap_en_type err_en,
   output logic capture_locked,
   output logic irq
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   lecap_pkg::lecap_state_type state_reg;
   lecap_pkg::lecap_state_type state_next;
   lecap_pkg::lecap_cap_type cap_new;
   logic [31:0] addr_reg;
   logic [31:0] devid_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_word;
   logic pslverr_reg;
   logic err_seen;
   logic log_hit;
   logic do_capture;
   logic setup;
   logic access;
   logic wr_done;
   logic rd_done;
   logic hit_addr;
   logic hit_devid;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic hit_any;
   logic ctrl_clear;
   logic stat_rd;
   logic [`LECAP_NIRQ-1:0] irq_events;
   logic [`LECAP_NIRQ-1:0] irq_status;
   logic [`LECAP_NIRQ-1:0] irq_mask;
   logic [`LECAP_NIRQ-1:0] stat_returned_reg;

   // ----------------------------------------
   // packet decode
   // ----------------------------------------
   lecap_pkt_decode u_decode (
      .pkt(pkt),
      .en(err_en),
      .err_seen(err_seen),
      .log_hit(log_hit),
      .cap(cap_new)
   );

   // ----------------------------------------
   // apb phase and address decode
   // ----------------------------------------
   // zero wait state in access: read data was fetched in setup
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_addr = (paddr == `LECAP_OFF_ADDR);
   assign hit_devid = (paddr == `LECAP_OFF_DEVID);
   assign hit_ctrl = (paddr == `LECAP_OFF_CTRL);
   assign hit_stat = (paddr == `LECAP_OFF_STAT);
   assign hit_mask = (paddr == `LECAP_OFF_MASK);
   assign hit_any = hit_addr || hit_devid || hit_ctrl || hit_stat || hit_mask;
   assign wr_done = access && pwrite && hit_any;
   assign rd_done = access && !pwrite;
   assign stat_rd = rd_done && hit_stat;
   assign pready = access;

   // ----------------------------------------
   // lock state
   // ----------------------------------------
   // capture only while open; the first enabled error wins
   assign do_capture = (state_reg == lecap_pkg::lecap_open) && log_hit;
   // all-zero write to control capture reopens the bank
   assign ctrl_clear = wr_done && hit_ctrl && (pwdata == `LECAP_CTRL_CLEAR);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         lecap_pkg::lecap_open: begin
            if (log_hit) begin
               state_next = lecap_pkg::lecap_locked;
            end
         end
         lecap_pkg::lecap_locked: begin
            // a fresh error in the clearing cycle keeps the bank locked, with the old address and source id capture but a zeroed control word
            if (ctrl_clear && !log_hit) begin
               state_next = lecap_pkg::lecap_open;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= lecap_pkg::lecap_open;
      end else begin
         state_reg <= state_next;
      end
   end

   assign capture_locked = (state_reg == lecap_pkg::lecap_locked);

   // ----------------------------------------
   // address capture
   // ----------------------------------------
   // hardware capture takes priority over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= `LECAP_RESET_WORD;
      end else if (do_capture) begin
         addr_reg <= cap_new.addr_word;
      end else if (wr_done && hit_addr) begin
         addr_reg <= pwdata & `LECAP_ADDR_WMASK;
      end
   end

   // ----------------------------------------
   // source id capture
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         devid_reg <= `LECAP_RESET_WORD;
      end else if (do_capture) begin
         devid_reg <= cap_new.devid_word;
      end else if (wr_done && hit_devid) begin
         devid_reg <= pwdata & `LECAP_DEVID_WMASK;
      end
   end

   // ----------------------------------------
   // control capture
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `LECAP_RESET_WORD;
      end else if (do_capture) begin
         ctrl_reg <= cap_new.ctrl_word;
      end else if (wr_done && hit_ctrl) begin
         ctrl_reg <= pwdata & `LECAP_CTRL_WMASK;
      end
   end

   // ----------------------------------------
   // interrupt events
   // ----------------------------------------
   // missed: an enabled error arrived while the bank was frozen
   always_comb begin
      irq_events = '0;
      irq_events[`LECAP_IRQ_CAPTURE] = do_capture;
      irq_events[`LECAP_IRQ_MISSED] = log_hit && (state_reg == lecap_pkg::lecap_locked);
      irq_events[`LECAP_IRQ_UNLOGGED] = err_seen && !log_hit;
   end

   lecap_irq u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .events(irq_events),
      .rd_clr(stat_rd),
      .clr_bits(stat_returned_reg),
      .mask_wr(wr_done && hit_mask),
      .mask_wdata(pwdata[`LECAP_NIRQ-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // ----------------------------------------
   // read data and error answer
   // ----------------------------------------
   // unused bits of status and mask read as zero
   always_comb begin
      rd_word = '0;
      if (hit_addr) begin
         rd_word = addr_reg;
      end else if (hit_devid) begin
         rd_word = devid_reg;
      end else if (hit_ctrl) begin
         rd_word = ctrl_reg;
      end else if (hit_stat) begin
         rd_word[`LECAP_NIRQ-1:0] = irq_status;
      end else if (hit_mask) begin
         rd_word[`LECAP_NIRQ-1:0] = irq_mask;
      end
   end

   // sampled in setup so prdata is a flop when pready rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= `LECAP_RESET_WORD;
         stat_returned_reg <= '0;
      end else if (setup) begin
         prdata_reg <= pwrite ? `LECAP_RESET_WORD : rd_word;
         stat_returned_reg <= irq_status;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         pslverr_reg <= !hit_any;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg && access;

endmodule : lecap_top
`default_nettype wire

// file: lecap_monitor.sv
// lecap_monitor.sv: port checker of the capture bank
// assumes: bound to lecap_top, single pclk domain
`timescale 1ns/1ps
`include "lecap_cfg.svh"
`default_nettype none
module lecap_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`LECAP_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire lecap_pkg::lecap_pkt_type pkt,
   input wire lecap_pkg::lecap_en_type err_en,
   input wire logic capture_locked,
   input wire logic irq
);
   logic hit;
   logic errs;
   logic clr;
   assign errs = pkt.err_ill_trans | pkt.err_ill_resp | pkt.err_unsup;
   assign hit = pkt.valid && pkt.hop == `LECAP_HOP_ZERO && pkt.kind != lecap_pkg::lecap_other
      && ((pkt.err_ill_trans & err_en.ill_trans_en) | (pkt.err_ill_resp & err_en.ill_resp_en)
      | (pkt.err_unsup & err_en.unsup_en));
   assign clr = psel && penable && pwrite && paddr == `LECAP_OFF_CTRL && pwdata == `LECAP_CTRL_CLEAR;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // read sequence, reserved bits, lock, filter and zero wait checks
   // ----------------------------------------
   sequence s_rd(off);
      psel && !penable && !pwrite && paddr == off ##1 psel && penable;
   endsequence
   property p_rsvd(off, m);
      s_rd(off) |-> (prdata & ~m) == 32'h0000_0000;
   endproperty
   a_lock_on_error: assert property (!capture_locked && hit |=> capture_locked)
      else $error("no lock after enabled error");
   a_lock_hold: assert property (capture_locked && !clr |=> capture_locked)
      else $error("lock dropped without clear");
   a_hop_filter: assert property (!capture_locked && pkt.valid && pkt.hop != 8'h00 |=> !capture_locked)
      else $error("locked on nonzero hop");
   a_kind_filter: assert property (!capture_locked && pkt.valid && pkt.kind == lecap_pkg::lecap_other
      |=> !capture_locked)
      else $error("locked on non maintenance packet");
   a_clean_request: assert property (!capture_locked && pkt.valid && !errs |=> !capture_locked)
      else $error("locked on error free packet");
   a_unlock_clear: assert property (capture_locked && clr && !hit |=> !capture_locked)
      else $error("zero write did not unlock");
   a_addr_rsvd: assert property (p_rsvd(`LECAP_OFF_ADDR, 32'h00ff_fffa))
      else $error("address reserved bits set");
   a_devid_rsvd: assert property (p_rsvd(`LECAP_OFF_DEVID, 32'h0000_ffff))
      else $error("source id reserved bits set");
   a_ctrl_rsvd: assert property (p_rsvd(`LECAP_OFF_CTRL, 32'hff00_0000))
      else $error("control reserved bits set");
   a_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("access phase not ready");
endmodule : lecap_monitor
bind lecap_top lecap_monitor lecap_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pkt, .err_en, .capture_locked, .irq);
`default_nettype wire

// file: lecap_pkt_source.sv
// lecap_pkt_source.sv: remote packet device model feeding packet reports
// assumes: pclk from the bench; one report per send call
`timescale 1ns/1ps
`default_nettype none
module lecap_pkt_source (
   input wire logic pclk,
   output var lecap_pkg::lecap_pkt_type pkt
);
   initial pkt = '0;
   // report stands one cycle; then the inverse, so stale fields never pass as held
   task automatic send(input lecap_pkg::lecap_pkt_type p);
      lecap_pkg::lecap_pkt_type q;
      @(posedge pclk);
      pkt <= p;
      @(posedge pclk);
      q = ~p;
      q.valid = 1'b0;
      pkt <= q;
   endtask : send
endmodule : lecap_pkt_source
`default_nettype wire

// file: logical_error_capture_bench.sv
// logical_error_capture_bench.sv: self-checking bench of the capture bank
// assumes: lecap_top, lecap_pkt_source and the checker compiled first
`timescale 1ns/1ps
`include "lecap_cfg.svh"
`default_nettype none
module logical_error_capture_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [12:0] paddr = 13'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   lecap_pkg::lecap_pkt_type pkt;
   lecap_pkg::lecap_en_type err_en = 3'h6;
   logic capture_locked;
   logic irq;
   logic [31:0] rd;
   logic err_seen;
   logic [12:0] offs [3] = '{`LECAP_OFF_ADDR, `LECAP_OFF_DEVID, `LECAP_OFF_CTRL};
   logic [31:0] wm [3] = '{32'h00ff_fffa, 32'h0000_ffff, 32'hff00_0000};
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   always #5 pclk = ~pclk;
   lecap_top lecap_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pkt(pkt), .err_en(err_en), .capture_locked(capture_locked), .irq(irq));
   lecap_pkt_source lecap_pkt_source_inst (.pclk(pclk), .pkt(pkt));
   // ----------------------------------------
   // report, bus and packet tasks
   // ----------------------------------------
   task automatic complete_run;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // no wait count assumed; the cycle ceiling ends a hang
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input string nm, input logic [12:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd);
      chk(nm, e, rd);
   endtask : rdc
   function automatic lecap_pkg::lecap_pkt_type mk(input lecap_pkg::lecap_kind_type k, input logic [7:0] h,
      input logic [1:0] tt, input logic [2:0] e, input logic [3:0] ty);
      mk = '{1'b1, k, h, tt, 4'h8, ty, 16'hc3a5, 16'hbeef, 21'h155aa3, 1'b1, e[2], e[1], e[0]};
   endfunction : mk
   task automatic nolock(input lecap_pkg::lecap_kind_type k, input logic [7:0] h, input logic [2:0] e);
      lecap_pkt_source_inst.send(mk(k, h, 2'h0, e, 4'h6));
      @(negedge pclk);
      chk("unlocked", 32'h0, {31'h0, capture_locked});
   endtask : nolock
   task automatic cap(input lecap_pkg::lecap_kind_type k, input logic [1:0] tt, input logic [2:0] e,
      input logic [3:0] ty, input logic [31:0] dev);
      lecap_pkt_source_inst.send(mk(k, 8'h00, tt, e, ty));
      @(negedge pclk);
      chk("locked", 32'h1, {31'h0, capture_locked});
      if (k == lecap_pkg::lecap_req) rdc("addr", `LECAP_OFF_ADDR, {8'h00, 21'h155aa3, 3'b010});
      rdc("devid", `LECAP_OFF_DEVID, dev);
      rdc("ctrl", `LECAP_OFF_CTRL, {4'h8, ty, 24'h000000});
   endtask : cap
   task automatic unlock;
      wr(`LECAP_OFF_CTRL, 32'h0000_0000);
      @(negedge pclk);
      chk("unlock", 32'h0, {31'h0, capture_locked});
   endtask : unlock
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         complete_run;
      end
   end
   // ----------------------------------------
   // sequence of tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rdc("reset", offs[i], 32'h0);
         wr(offs[i], 32'hffff_ffff);
         rdc("rw bits", offs[i], wm[i]);
         wr(offs[i], 32'h0);
      end
      apb(1'b0, 13'h1000, 32'h0, rd);
      chk("unmapped", 32'h1, {31'h0, err_seen});
      wr(`LECAP_OFF_MASK, 32'h0);
      nolock(lecap_pkg::lecap_req, 8'h01, 3'b100);
      nolock(lecap_pkg::lecap_other, 8'h00, 3'b100);
      nolock(lecap_pkg::lecap_req, 8'h00, 3'b001);
      nolock(lecap_pkg::lecap_req, 8'h00, 3'b000);
      rdc("untouched", `LECAP_OFF_ADDR, 32'h0);
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b0, `LECAP_OFF_STAT, 32'h0, rd);
      chk("unlogged", 32'h1, {31'h0, rd[2]});
      wr(`LECAP_OFF_MASK, 32'h7);
      rdc("mask", `LECAP_OFF_MASK, 32'h0000_0007);
      err_en <= 3'h7;
      cap(lecap_pkg::lecap_req, 2'h1, 3'b100, 4'h6, 32'h0000_c3a5);
      chk("irq", 32'h1, {31'h0, irq});
      lecap_pkt_source_inst.send(mk(lecap_pkg::lecap_req, 8'h00, 2'h0, 3'b100, 4'h9));
      rdc("frozen ctrl", `LECAP_OFF_CTRL, 32'h8600_0000);
      rdc("frozen devid", `LECAP_OFF_DEVID, 32'h0000_c3a5);
      apb(1'b0, `LECAP_OFF_STAT, 32'h0, rd);
      chk("status", 32'h3, {30'h0, rd[1:0]});
      repeat (2) @(negedge pclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      unlock();
      cap(lecap_pkg::lecap_resp, 2'h0, 3'b010, 4'h3, 32'h0000_00a5);
      unlock();
      cap(lecap_pkg::lecap_pwrite, 2'h2, 3'b001, 4'h4, 32'h0000_beef);
      unlock();
      cap(lecap_pkg::lecap_req, 2'h3, 3'b100, 4'hc, 32'h0000_beef);
      unlock();
      complete_run();
   end
endmodule : logical_error_capture_bench
`default_nettype wire
